// ---- hdl/rbm_pkg.sv ----
package rbm_pkg;

   // core clock and derived cycle rates
   localparam int unsigned CLK_HZ           = 50_000_000;
   // one processor cycle spans this many core clocks
   localparam int unsigned PROC_CYCLE_CLKS  = 2;
   // the processor cycle runs at twice the input clock
   localparam int unsigned IN_PER_PROC      = 2;
   localparam int unsigned CLK_PER_IN       = PROC_CYCLE_CLKS * IN_PER_PROC;
   localparam int unsigned IN_CNT_W         = 4;

   // input clock edges needed for the clock multiplier to lock
   localparam int unsigned PLL_LOCK_IN_CYCLES = 2000;
   localparam int unsigned LOCK_CNT_W         = 11;

   // words copied from byte memory before execution may start
   localparam int unsigned BOOT_WORDS   = 32;
   localparam int unsigned BOOT_CNT_W   = 6;

   // first fetch address after boot, internal or external
   localparam logic [13:0] START_ADDR   = 14'h0000;

   // register map, byte addresses
   localparam logic [7:0] ADR_CTRL      = 8'h00;
   localparam logic [7:0] ADR_MODE_STATUS_REGISTER     = 8'h04;
   localparam logic [7:0] ADR_IMASK     = 8'h08;
   localparam logic [7:0] ADR_STATUS    = 8'h0C;

   localparam int unsigned MODE_STATUS_REGISTER_W      = 7;
   localparam int unsigned IMASK_W      = 10;
   localparam logic [MODE_STATUS_REGISTER_W-1:0] MODE_STATUS_REGISTER_RST = 7'h00;
   localparam logic [IMASK_W-1:0] IMASK_RST = 10'h000;

   // synchronised pin count
   localparam int unsigned SYNC_W       = 7;

   typedef struct packed {
      logic ack_open;    // 1: acknowledge is open-source
      logic host_mode;   // 1: host memory mode, 0: full memory mode
      logic no_boot;     // 1: no automatic boot
      logic host_boot;   // 1: boot through host port, 0: byte memory
   } rbm_straps_t;

   localparam rbm_straps_t STRAPS_RST = 4'h0;

   typedef struct packed {
      logic [28:0] unused;
      logic        flag_out;
      logic        flag_dir;             // 1: flag pin two is an output
      logic        clock_output_disable;
   } rbm_ctrl_t;

   localparam rbm_ctrl_t CTRL_RST = 32'h0000_0000;

   typedef enum logic [5:0] {
      ST_RESET     = 6'h01,
      ST_WAIT_BUS  = 6'h02,
      ST_BOOT_BYTE = 6'h04,
      ST_BOOT_HOST = 6'h08,
      ST_RUN       = 6'h10,
      ST_HALT      = 6'h20
   } rbm_state_t;

   typedef struct packed {
      logic [11:0]           unused;
      logic [BOOT_CNT_W-1:0] boot_count;
      logic                  flag_in;
      logic                  clock_ratio_ok;
      logic                  pll_locked;
      logic                  unsupported;
      rbm_state_t            state;
      rbm_straps_t           straps;
   } rbm_status_t;

endpackage : rbm_pkg

// ---- hdl/rbm_sync.sv ----
`timescale 1ns/10ps
`default_nettype none

module rbm_sync #(
   parameter int unsigned WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // asynchronous levels in, synchronised levels out
   input  wire logic [WIDTH-1:0] async_i,
   output var  logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;

   assign sync_o = stage2;

   // first stage feeds only the second
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stage1 <= '0;
         stage2 <= '0;
      end else begin
         stage1 <= async_i;
         stage2 <= stage1;
      end
   end

endmodule : rbm_sync

`default_nettype wire

// ---- hdl/rbm_ctrl.sv ----
// Decided for this implementation: the Wishbone slave port and the address map.
`timescale 1ns/10ps
`default_nettype none

module rbm_ctrl
   import rbm_pkg::*;
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output var  logic [31:0] wb_dat_o,
   output var  logic        wb_ack_o,
   // device pins
   input  wire logic        input_clock_pin_i,
   input  wire logic        reset_pin_n_i,
   input  wire logic        strap_boot_source_i,
   input  wire logic        strap_auto_boot_i,
   input  wire logic        strap_ack_drive_i,
   input  wire logic        bus_request_i,
   // flag pin two, also the memory-mode strap
   input  wire logic        flag_pin_two_i,
   output var  logic        flag_pin_two_o,
   output var  logic        flag_pin_two_oe_o,
   // host acknowledge pin
   output var  logic        host_access_acknowledge_o,
   output var  logic        host_access_acknowledge_oe_o,
   output var  logic        cycle_clock_output_o,
   // core side
   input  wire logic        host_ack_req_i,
   input  wire logic        boot_word_done_i,
   input  wire logic        host_pm0_write_i,
   output var  logic        core_reset_o,
   output var  logic        byte_dma_boot_o,
   output var  logic        exec_enable_o,
   output var  logic        exec_external_o,
   output var  logic [13:0] fetch_addr_o,
   output var  logic        host_mode_o,
   output var  logic [MODE_STATUS_REGISTER_W-1:0] mode_status_register_o,
   output var  logic [IMASK_W-1:0] imask_o
);

   // synchronised pins
   logic [SYNC_W-1:0] pins_s;
   logic              in_clk_s;
   logic              rst_pin_n_s;
   logic              bus_req_s;
   logic              flag_in_s;
   rbm_straps_t       straps_s;

   rbm_sync #(
      .WIDTH (SYNC_W)
   ) u_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i ({input_clock_pin_i, reset_pin_n_i, bus_request_i,
                 strap_ack_drive_i, flag_pin_two_i, strap_auto_boot_i,
                 strap_boot_source_i}),
      .sync_o  (pins_s)
   );

   assign in_clk_s    = pins_s[6];
   assign rst_pin_n_s = pins_s[5];
   assign bus_req_s   = pins_s[4];
   assign straps_s    = rbm_straps_t'(pins_s[3:0]);
   assign flag_in_s   = pins_s[2];

   // state
   logic                  in_clk_q;
   logic [IN_CNT_W-1:0]   in_cnt;
   logic                  ratio_ok;
   logic [LOCK_CNT_W-1:0] lock_cnt;
   logic                  pll_locked;
   rbm_straps_t           straps;
   rbm_state_t            state;
   logic [BOOT_CNT_W-1:0] boot_cnt;
   logic                  cyc_tog;
   rbm_ctrl_t             ctrl;
   logic [MODE_STATUS_REGISTER_W-1:0]    mode_status_register;
   logic [IMASK_W-1:0]    imask;

   logic                  next_in_clk_q;
   logic [IN_CNT_W-1:0]   next_in_cnt;
   logic                  next_ratio_ok;
   logic [LOCK_CNT_W-1:0] next_lock_cnt;
   logic                  next_pll_locked;
   rbm_straps_t           next_straps;
   rbm_state_t            next_state;
   logic [BOOT_CNT_W-1:0] next_boot_cnt;
   logic                  next_cyc_tog;
   rbm_ctrl_t             next_ctrl;
   logic [MODE_STATUS_REGISTER_W-1:0]    next_mode_status_register;
   logic [IMASK_W-1:0]    next_imask;
   logic [31:0]           next_wb_dat;
   logic                  next_wb_ack;

   logic                  in_edge;
   logic                  master_rst;
   logic                  unsupported;
   logic                  wb_req;
   rbm_status_t           status;

   assign in_edge = in_clk_s & ~in_clk_q;
   // locked flag only clears on power-up reset
   // no relock wait
   assign master_rst = rst_i | ~rst_pin_n_s | ~pll_locked;
   // host mode without boot, or host-port boot in full mode
   // unsupported combinations
   assign unsupported = (straps.host_mode & straps.no_boot) |
                        (~straps.host_mode & straps.host_boot);
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

   // input clock supervision and multiplier lock
   always_comb begin
      next_in_clk_q   = in_clk_s;
      next_in_cnt     = in_cnt;
      next_ratio_ok   = ratio_ok;
      next_lock_cnt   = lock_cnt;
      next_pll_locked = pll_locked;
      if (in_edge) begin
         next_in_cnt   = '0;
         next_ratio_ok = (in_cnt == IN_CNT_W'(CLK_PER_IN - 1));
      end else if (in_cnt != '1) begin
         next_in_cnt = in_cnt + IN_CNT_W'(1);
      end
      if (!pll_locked && in_edge) begin
         if (lock_cnt == LOCK_CNT_W'(PLL_LOCK_IN_CYCLES - 1)) begin
            next_pll_locked = 1'b1;
         end else begin
            next_lock_cnt = lock_cnt + LOCK_CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         in_clk_q   <= 1'b0;
         in_cnt     <= '0;
         ratio_ok   <= 1'b0;
         lock_cnt   <= '0;
         pll_locked <= 1'b0;
      end else begin
         in_clk_q   <= next_in_clk_q;
         in_cnt     <= next_in_cnt;
         ratio_ok   <= next_ratio_ok;
         lock_cnt   <= next_lock_cnt;
         pll_locked <= next_pll_locked;
      end
   end

   // straps and boot sequencing
   always_comb begin
      next_straps   = straps;
      next_state    = state;
      next_boot_cnt = boot_cnt;
      // last value seen while reset pin is low is the one kept
      // strap sampling
      if (!rst_pin_n_s) begin
         next_straps = straps_s;
      end
      case (state)
         ST_RESET: begin
            next_boot_cnt = '0;
            if (!master_rst) begin
               if (unsupported) begin
                  next_state = ST_HALT;
               end else if (straps.no_boot) begin
                  next_state = ST_RUN;
               end else if (bus_req_s) begin
                  next_state = ST_WAIT_BUS;
               end else if (straps.host_boot) begin
                  next_state = ST_BOOT_HOST;
               end else begin
                  next_state = ST_BOOT_BYTE;
               end
            end
         end
         ST_WAIT_BUS: begin
            if (!bus_req_s) begin
               next_state = straps.host_boot ? ST_BOOT_HOST : ST_BOOT_BYTE;
            end
         end
         ST_BOOT_BYTE: begin
            if (boot_word_done_i) begin
               next_boot_cnt = boot_cnt + BOOT_CNT_W'(1);
               if (boot_cnt == BOOT_CNT_W'(BOOT_WORDS - 1)) begin
                  next_state = ST_RUN;
               end
            end
         end
         ST_BOOT_HOST: begin
            if (host_pm0_write_i) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN:  next_state = ST_RUN;
         ST_HALT: next_state = ST_HALT;
         default: next_state = ST_RESET;
      endcase
      if (master_rst) begin
         next_state = ST_RESET;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         straps   <= STRAPS_RST;
         state    <= ST_RESET;
         boot_cnt <= '0;
      end else begin
         straps   <= next_straps;
         state    <= next_state;
         boot_cnt <= next_boot_cnt;
      end
   end

   // register file and wishbone slave
   always_comb begin
      next_ctrl   = ctrl;
      next_mode_status_register  = mode_status_register;
      next_imask  = imask;
      next_wb_ack = wb_req;
      next_wb_dat = 32'h0000_0000;
      if (wb_req && wb_we_i) begin
         case (wb_adr_i)
            ADR_CTRL: begin
               if (wb_sel_i[0]) begin
                  next_ctrl.clock_output_disable = wb_dat_i[0];
                  next_ctrl.flag_dir             = wb_dat_i[1];
                  next_ctrl.flag_out             = wb_dat_i[2];
               end
            end
            ADR_MODE_STATUS_REGISTER: begin
               if (wb_sel_i[0]) begin
                  next_mode_status_register = wb_dat_i[MODE_STATUS_REGISTER_W-1:0];
               end
            end
            ADR_IMASK: begin
               if (wb_sel_i[0]) begin
                  next_imask[7:0] = wb_dat_i[7:0];
               end
               if (wb_sel_i[1]) begin
                  next_imask[IMASK_W-1:8] = wb_dat_i[IMASK_W-1:8];
               end
            end
            default: next_ctrl = ctrl;
         endcase
      end
      if (wb_req && !wb_we_i) begin
         case (wb_adr_i)
            ADR_CTRL:   next_wb_dat = ctrl;
            ADR_MODE_STATUS_REGISTER:  next_wb_dat = 32'(mode_status_register);
            ADR_IMASK:  next_wb_dat = 32'(imask);
            ADR_STATUS: next_wb_dat = status;
            default:    next_wb_dat = 32'h0000_0000;
         endcase
      end
      // reset clear wins over a software write
      // mask and clear
      if (master_rst) begin
         next_mode_status_register = MODE_STATUS_REGISTER_RST;
         next_imask = IMASK_RST;
      end
   end

   always_comb begin
      status                = '0;
      status.boot_count     = boot_cnt;
      status.flag_in        = flag_in_s;
      status.clock_ratio_ok = ratio_ok;
      status.pll_locked     = pll_locked;
      status.unsupported    = unsupported;
      status.state          = state;
      status.straps         = straps;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl     <= CTRL_RST;
         mode_status_register    <= MODE_STATUS_REGISTER_RST;
         imask    <= IMASK_RST;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         ctrl     <= next_ctrl;
         mode_status_register    <= next_mode_status_register;
         imask    <= next_imask;
         wb_ack_o <= next_wb_ack;
         wb_dat_o <= next_wb_dat;
      end
   end

   // pin and core outputs, all registered
   always_comb begin
      next_cyc_tog = ~cyc_tog;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cyc_tog                      <= 1'b0;
         cycle_clock_output_o         <= 1'b0;
         flag_pin_two_o               <= 1'b0;
         flag_pin_two_oe_o            <= 1'b0;
         host_access_acknowledge_o    <= 1'b1;
         host_access_acknowledge_oe_o <= 1'b0;
         core_reset_o                 <= 1'b1;
         byte_dma_boot_o              <= 1'b0;
         exec_enable_o                <= 1'b0;
         exec_external_o              <= 1'b0;
         fetch_addr_o                 <= START_ADDR;
         host_mode_o                  <= 1'b0;
         mode_status_register_o       <= MODE_STATUS_REGISTER_RST;
         imask_o                      <= IMASK_RST;
      end else begin
         cyc_tog <= next_cyc_tog;
         // clock keeps running through a pin reset
         // gated clock out
         cycle_clock_output_o <= next_cyc_tog &
                                 ~ctrl.clock_output_disable;
         // pin released while it serves as a strap
         // shared flag pin
         flag_pin_two_o    <= ctrl.flag_out;
         flag_pin_two_oe_o <= rst_pin_n_s & ctrl.flag_dir;
         // acknowledge pin is active low; open-source drives only high
         // acknowledge drive
         host_access_acknowledge_o <= straps.ack_open | ~host_ack_req_i;
         host_access_acknowledge_oe_o <= ~master_rst & straps.host_mode &
                                         (~straps.ack_open | ~host_ack_req_i);
         core_reset_o    <= master_rst;
         byte_dma_boot_o <= (next_state == ST_BOOT_BYTE);
         exec_enable_o   <= (next_state == ST_RUN);
         exec_external_o <= (next_state == ST_RUN) & straps.no_boot &
                            ~straps.host_mode;
         fetch_addr_o    <= START_ADDR;
         host_mode_o     <= straps.host_mode;
         mode_status_register_o <= next_mode_status_register;
         imask_o                <= next_imask;
      end
   end

endmodule : rbm_ctrl

`default_nettype wire

// ---- testbench/rbm_ctrl_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none

module rbm_ctrl_chk
   import rbm_pkg::*;
(
   // clock and reset
   input wire logic               clk_i,
   input wire logic               rst_i,
   // bus handshake
   input wire logic               wb_cyc_i,
   input wire logic               wb_stb_i,
   input wire logic               wb_ack_o,
   // pins and core side
   input wire logic               reset_pin_n_i,
   input wire logic               flag_pin_two_oe_o,
   input wire logic               host_access_acknowledge_oe_o,
   input wire logic               cycle_clock_output_o,
   input wire logic               core_reset_o,
   input wire logic               byte_dma_boot_o,
   input wire logic               exec_enable_o,
   input wire logic               exec_external_o,
   input wire logic [13:0]        fetch_addr_o,
   input wire logic               host_mode_o,
   input wire logic [MODE_STATUS_REGISTER_W-1:0] mode_status_register_o,
   input wire logic [IMASK_W-1:0] imask_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_ack_answer: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request was not answered in one cycle");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack stood longer than one cycle");
   a_clk_out_pulse: assert property (
      cycle_clock_output_o |=> !cycle_clock_output_o)
      else $error("cycle clock high for more than one clock");
   a_reset_clears: assert property (
      core_reset_o && $past(core_reset_o) |->
      mode_status_register_o == '0 && imask_o == '0)
      else $error("mode status or mask not clear in reset");
   a_fetch_zero: assert property (fetch_addr_o == START_ADDR)
      else $error("fetch address not zero");
   a_exec_clean: assert property (
      $rose(exec_enable_o) |-> !core_reset_o)
      else $error("execution began inside master reset");
   a_boot_holds: assert property (
      byte_dma_boot_o |-> !exec_enable_o)
      else $error("execution during byte boot");
   a_ack_full_mode: assert property (
      !host_mode_o && !$past(host_mode_o) |->
      !host_access_acknowledge_oe_o)
      else $error("acknowledge driven in full memory mode");
   a_flag_released: assert property (
      (!reset_pin_n_i) [*5] |-> !flag_pin_two_oe_o)
      else $error("flag pin driven while reset pin low");

   c_exec: cover property ($rose(exec_enable_o));
   c_byte_done: cover property ($fell(byte_dma_boot_o));
   c_external: cover property ($rose(exec_external_o));
   c_ack_drive: cover property (host_access_acknowledge_oe_o);
endmodule : rbm_ctrl_chk

bind rbm_ctrl rbm_ctrl_chk u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .reset_pin_n_i(reset_pin_n_i), .flag_pin_two_oe_o(flag_pin_two_oe_o),
   .host_access_acknowledge_oe_o(host_access_acknowledge_oe_o),
   .cycle_clock_output_o(cycle_clock_output_o),
   .core_reset_o(core_reset_o), .byte_dma_boot_o(byte_dma_boot_o),
   .exec_enable_o(exec_enable_o), .exec_external_o(exec_external_o),
   .fetch_addr_o(fetch_addr_o), .host_mode_o(host_mode_o),
   .mode_status_register_o(mode_status_register_o), .imask_o(imask_o));

`default_nettype wire

// ---- testbench/rbm_board.sv ----
`timescale 1ns/10ps
`default_nettype none

module rbm_board (
   // bench control
   input  wire logic       clk_i,
   input  wire logic       hold_reset_i,
   input  wire logic [3:0] straps_i,
   input  wire logic       pull_i,
   // pin outputs of the device
   input  wire logic       flag_o_i,
   input  wire logic       flag_oe_i,
   input  wire logic       ack_o_i,
   input  wire logic       ack_oe_i,
   // board side levels
   output var  logic       input_clock_o,
   output var  logic       reset_n_o,
   output var  logic       strap_a_o,
   output var  logic       strap_b_o,
   output var  logic       strap_d_o,
   output var  logic       flag_level_o,
   output var  logic       ack_level_o
);
   logic [1:0] phase = 2'h0;

   always_ff @(posedge clk_i) begin
      phase <= phase + 2'h1;
   end
   assign input_clock_o = phase[1];
   assign reset_n_o     = !hold_reset_i;
   assign strap_a_o     = straps_i[0];
   assign strap_b_o     = straps_i[1];
   assign strap_d_o     = straps_i[3];
   assign flag_level_o  = flag_oe_i ? flag_o_i :
                          (hold_reset_i ? straps_i[2] : pull_i);
   assign ack_level_o   = ack_oe_i ? ack_o_i : 1'b0;
endmodule : rbm_board

`default_nettype wire

// ---- testbench/rbm_ctrl_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin \
   num_errors++; $display("CHECK FAILED %s exp %0h seen %0h", n, e, s); \
   end end

module rbm_ctrl_tb
   import rbm_pkg::*;
();
   logic clk_i, rst_i, cyc, stb, we, bus_req, ack_req, word, pm0, hold, pull;
   logic [7:0] adr;
   logic [31:0] wdat, rdat, q, m;
   logic [3:0] straps, s;
   logic [5:0] st;
   logic ack, flag_o, flag_oe, hk_o, hk_oe, clko, core_rst, byte_boot;
   logic exec_en, exec_ext, host_mode, in_clk, rst_n, sa, sb, sd;
   logic flag_lvl, ack_lvl, a;
   logic [13:0] fetch;
   logic [MODE_STATUS_REGISTER_W-1:0] mode_status_register;
   logic [IMASK_W-1:0] imask;
   logic [3:0] modes [8] = '{4'h0, 4'h2, 4'h4, 4'h5, 4'hC, 4'hD, 4'h6, 4'h3};
   int num_errors = 0;
   int compares = 0;

   rbm_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .input_clock_pin_i(in_clk), .reset_pin_n_i(rst_n),
      .strap_boot_source_i(sa), .strap_auto_boot_i(sb),
      .strap_ack_drive_i(sd), .bus_request_i(bus_req),
      .flag_pin_two_i(flag_lvl), .flag_pin_two_o(flag_o),
      .flag_pin_two_oe_o(flag_oe), .host_access_acknowledge_o(hk_o),
      .host_access_acknowledge_oe_o(hk_oe), .cycle_clock_output_o(clko),
      .host_ack_req_i(ack_req), .boot_word_done_i(word),
      .host_pm0_write_i(pm0), .core_reset_o(core_rst),
      .byte_dma_boot_o(byte_boot), .exec_enable_o(exec_en),
      .exec_external_o(exec_ext), .fetch_addr_o(fetch),
      .host_mode_o(host_mode), .mode_status_register_o(mode_status_register),
      .imask_o(imask));

   rbm_board u_board (.clk_i(clk_i), .hold_reset_i(hold), .straps_i(straps),
      .pull_i(pull), .flag_o_i(flag_o), .flag_oe_i(flag_oe), .ack_o_i(hk_o),
      .ack_oe_i(hk_oe), .input_clock_o(in_clk), .reset_n_o(rst_n),
      .strap_a_o(sa), .strap_b_o(sb), .strap_d_o(sd),
      .flag_level_o(flag_lvl), .ack_level_o(ack_lvl));

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   function automatic logic [5:0] exp_state(input logic [3:0] v);
      if ((v[2] && v[1]) || (!v[2] && v[0])) return 6'h20;
      if (v[1]) return 6'h10;
      return v[0] ? 6'h08 : 6'h04;
   endfunction : exp_state

   task automatic report_and_stop();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : report_and_stop

   task automatic wb_io(input logic w, input logic [7:0] ad,
                        input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= ad; wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      `CHK("ack", 1'b1, ack)
   endtask : wb_io

   task automatic wait_core(input int lim);
      int n;
      n = 0;
      while (core_rst !== 1'b0 && n < lim) begin
         @(posedge clk_i);
         n++;
      end
      `CHK("core_reset", 1'b0, core_rst)
   endtask : wait_core

   task automatic pulse(input logic host);
      @(posedge clk_i);
      if (host) pm0 <= 1'b1;
      else word <= 1'b1;
      @(posedge clk_i);
      pm0 <= 1'b0; word <= 1'b0;
   endtask : pulse

   task automatic do_reset(input logic [3:0] v, input logic br);
      wb_io(1'b1, ADR_MODE_STATUS_REGISTER, 32'h7F);
      @(posedge clk_i);
      hold <= 1'b1; straps <= v; bus_req <= br;
      repeat (8) @(posedge clk_i);
      `CHK("flag_oe", 1'b0, flag_oe)
      hold <= 1'b0;
      repeat (5) @(posedge clk_i);
      straps <= ~v; pull <= 1'($urandom);
      wait_core(20);
      wb_io(1'b0, ADR_MODE_STATUS_REGISTER, 32'h0);
      `CHK("mode_status_register", 32'h0, q)
   endtask : do_reset

   initial begin
      repeat (30000) @(posedge clk_i);
      num_errors++;
      report_and_stop();
   end

   initial begin
      rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00;
      wdat = 32'h0; bus_req = 1'b0; ack_req = 1'b0; word = 1'b0;
      pm0 = 1'b0; hold = 1'b1; straps = 4'h2; pull = 1'b0;
      m = $urandom(32'hD5EF);
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (7800) @(posedge clk_i);
      wb_io(1'b0, ADR_STATUS, 32'h0);
      `CHK("lock_wait", 1'b0, q[11])
      repeat (400) @(posedge clk_i);
      wb_io(1'b0, ADR_STATUS, 32'h0);
      `CHK("locked", 1'b1, q[11])
      hold <= 1'b0;
      wait_core(20);
      repeat (3) @(posedge clk_i);
      `CHK("exec_ext", 1'b1, exec_ext)
      m = $urandom;
      wb_io(1'b1, ADR_MODE_STATUS_REGISTER, m);
      wb_io(1'b0, ADR_MODE_STATUS_REGISTER, 32'h0);
      `CHK("mode_status_register_rd", {25'h0, m[6:0]}, q)
      `CHK("mode_status_register_o", m[6:0], mode_status_register)
      wb_io(1'b1, ADR_IMASK, m);
      wb_io(1'b0, ADR_IMASK, 32'h0);
      `CHK("imask_rd", {22'h0, m[9:0]}, q)
      `CHK("imask_o", m[9:0], imask)
      wb_io(1'b1, ADR_STATUS, 32'hFFFF_FFFF);
      wb_io(1'b0, ADR_STATUS, 32'h0);
      `CHK("status_ro", 4'h2, q[3:0])
      wb_io(1'b0, 8'h10, 32'h0);
      `CHK("unmapped", 32'h0, q)
      wb_io(1'b1, ADR_CTRL, 32'h1);
      a = 1'b0;
      repeat (8) begin
         @(posedge clk_i);
         a = a | clko;
      end
      `CHK("clk_off", 1'b0, a)
      wb_io(1'b1, ADR_CTRL, 32'h6);
      repeat (3) @(posedge clk_i);
      a = clko;
      @(posedge clk_i);
      `CHK("clk_toggle", ~a, clko)
      `CHK("flag_lvl", 1'b1, flag_lvl)
      for (int i = 0; i < 8; i++) begin
         s = modes[i];
         if (!s[2]) s[3] = 1'($urandom);
         st = exp_state(s);
         do_reset(s, i == 0);
         if (i == 0) begin
            repeat (3) @(posedge clk_i);
            wb_io(1'b0, ADR_STATUS, 32'h0);
            `CHK("bus_wait", 6'h02, q[9:4])
            bus_req <= 1'b0;
         end
         repeat (3) @(posedge clk_i);
         wb_io(1'b0, ADR_STATUS, 32'h0);
         `CHK("straps", s, q[3:0])
         `CHK("flag_in", 1'b1, q[13])
         `CHK("state", st, q[9:4])
         `CHK("host_mode", s[2], host_mode)
         ack_req <= 1'($urandom);
         repeat (3) @(posedge clk_i);
         if (s[2]) begin
            `CHK("ack_lvl", ~ack_req, ack_lvl)
            `CHK("ack_oe", s[3] ? ~ack_req : 1'b1, hk_oe)
         end
         else `CHK("ack_oe", 1'b0, hk_oe)
         if (st == 6'h04) begin
            `CHK("byte_boot", 1'b1, byte_boot)
            repeat (31) pulse(1'b0);
            `CHK("exec_hold", 1'b0, exec_en)
            pulse(1'b0);
         end
         else if (st == 6'h08) begin
            `CHK("exec_hold", 1'b0, exec_en)
            pulse(1'b1);
         end
         repeat (2) @(posedge clk_i);
         `CHK("exec", st != 6'h20, exec_en)
         `CHK("byte_boot", 1'b0, byte_boot)
         `CHK("fetch", 14'h0000, fetch)
         if (st == 6'h10) `CHK("exec_ext", 1'b1, exec_ext)
      end
      report_and_stop();
   end
endmodule : rbm_ctrl_tb

`default_nettype wire
